// ### aar_defines.vh
`ifndef AAR_DEFINES_VH
`define AAR_DEFINES_VH

// ----------------------------------------
// Register word indices (byte address = 4 x index)
// ----------------------------------------
`define AAR_IDX_INSTR 3'h0
`define AAR_IDX_ACC 3'h1
`define AAR_IDX_STATUS 3'h2
`define AAR_IDX_FADDR 3'h3
`define AAR_IDX_FDATA 3'h4

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define AAR_OPC_HI 13
`define AAR_OPC_LO 8
`define AAR_OPC_ADD 6'h07
`define AAR_OPC_AND 6'h05
`define AAR_DEST_BIT 7
`define AAR_ADDR_HI 6
`define AAR_ADDR_LO 0

// ----------------------------------------
// Status register bit positions
// ----------------------------------------
`define AAR_BIT_CARRY 0
`define AAR_BIT_DCARRY 1
`define AAR_BIT_ZERO 2
`define AAR_BIT_BUSY 3
`define AAR_BIT_ILLEGAL 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AAR_RST_INSTR 14'h0000
`define AAR_RST_ACC 8'h00
`define AAR_RST_FADDR 7'h00

// ----------------------------------------
// Timing: wait cycles on a register read
// ----------------------------------------
`define AAR_RD_WAIT 2'h2

`endif

// ### aar_alu.v
`timescale 1ns/10ps
// Byte adder / AND unit with flag outputs
module aar_alu #(
    parameter WIDTH = 8
)
(
    input wire [WIDTH-1:0] acc_i, // Accumulator operand
    input wire [WIDTH-1:0] file_i, // File register operand
    input wire add_sel_i, // 1 = add, 0 = AND
    output reg [WIDTH-1:0] result_o, // Operation result
    output reg carry_o, // Carry out of top bit
    output reg digit_carry_o, // Carry out of bit 3
    output wire zero_o // Result is zero
);

    wire [WIDTH:0] sum_full;
    wire [4:0] low_sum;

    // ----------------------------------------
    // Full and low-nibble sums
    // ----------------------------------------
    assign sum_full = {1'b0, acc_i} + {1'b0, file_i};
    assign low_sum = {1'b0, acc_i[3:0]} + {1'b0, file_i[3:0]};

    // Result and carries by operation
    always @*
    begin
        if (add_sel_i)
        begin
            result_o = sum_full[WIDTH-1:0];
            carry_o = sum_full[WIDTH];
            digit_carry_o = low_sum[4];
        end
        else
        begin
            result_o = acc_i & file_i;
            carry_o = 1'b0;
            digit_carry_o = 1'b0;
        end
    end

    assign zero_o = (result_o == {WIDTH{1'b0}});

endmodule // aar_alu

// ### aar_regfile.v
`timescale 1ns/10ps
// Single-port file register memory, registered read data
module aar_regfile #(
    parameter WIDTH = 8,
    parameter AW = 7
)
(
    input wire clock_i, // Core clock
    input wire [AW-1:0] addr_i, // Word address
    input wire wr_en_i, // Write strobe
    input wire [WIDTH-1:0] wr_data_i, // Write data
    output reg [WIDTH-1:0] rd_data_o // Read data, one cycle late
);

    reg [WIDTH-1:0] mem_q [0:(1<<AW)-1];

    // ----------------------------------------
    // Write port and registered read
    // ----------------------------------------
    always @(posedge clock_i)
    begin
        if (wr_en_i)
        begin
            mem_q[addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_q[addr_i];
    end

endmodule // aar_regfile

// ### aar_core.v
`timescale 1ns/10ps
`include "aar_defines.vh"

// How it works
// - Opcode 000111 adds accumulator and file register, result to destination.
// - Opcode 000101 ANDs accumulator with file register, result to destination.
// - Destination bit 0 writes accumulator, file register untouched.
// - Destination bit 1 writes file register, accumulator untouched.
// - Add updates carry, digit carry, zero; AND updates zero only.
// - One instruction in four phases: decode, read, compute, write.
module aar_core #(
    parameter WIDTH = 8,
    parameter AW = 7
)
(
    input wire clock_i, // Core clock, 125 MHz
    input wire rst_n_i, // Asynchronous reset, active low
    input wire [4:0] avs_address_i, // Byte address
    input wire avs_read_i, // Read request
    input wire avs_write_i, // Write request
    input wire [31:0] avs_writedata_i, // Write data
    input wire [3:0] avs_byteenable_i, // Byte lanes
    output reg [31:0] avs_readdata_o, // Read data
    output wire avs_waitrequest_o, // Stall the master
    output wire [WIDTH-1:0] acc_o, // Accumulator contents
    output wire carry_flag_o, // Carry flag
    output wire digit_carry_flag_o, // Digit carry flag
    output wire zero_flag_o, // Zero flag
    output wire busy_o // Instruction in progress
);

    // ----------------------------------------
    // Phase sequencer states, one-hot
    // ----------------------------------------
    localparam [4:0] PH_IDLE = 5'h01;
    localparam [4:0] PH_Q1 = 5'h02;
    localparam [4:0] PH_Q2 = 5'h04;
    localparam [4:0] PH_Q3 = 5'h08;
    localparam [4:0] PH_Q4 = 5'h10;

    reg [4:0] phase_q, phase_d;
    reg [13:0] instr_q;
    reg [WIDTH-1:0] acc_q;
    reg carry_q, dcarry_q, zero_q, illegal_q;
    reg [AW-1:0] faddr_q;
    reg op_add_q, op_and_q, dest_file_q;
    reg [AW-1:0] op_addr_q;
    reg [WIDTH-1:0] result_q;
    reg res_c_q, res_dcy_q, res_z_q;
    reg [1:0] rd_cnt_q;

    wire [2:0] reg_idx;
    wire busy, wr_accept, rd_accept, start;
    wire [15:0] instr_merged;
    wire [WIDTH-1:0] mem_rdata;
    wire [WIDTH-1:0] alu_result;
    wire alu_c, alu_dcy, alu_z;
    wire mem_we, op_valid;
    wire [AW-1:0] mem_addr;
    wire [WIDTH-1:0] mem_wdata;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Merge write data into a 16-bit value under byte enables
    function [15:0] be_merge;
        input [15:0] old_val;
        input [15:0] new_val;
        input [1:0] be;
        be_merge = {be[1] ? new_val[15:8] : old_val[15:8],
                    be[0] ? new_val[7:0] : old_val[7:0]};
    endfunction

    // Decode the opcode field: 2'b01 add, 2'b10 AND, 2'b00 other
    function [1:0] op_decode;
        input [13:0] instr;
        case (instr[`AAR_OPC_HI:`AAR_OPC_LO])
            `AAR_OPC_ADD: op_decode = 2'h1;
            `AAR_OPC_AND: op_decode = 2'h2;
            default: op_decode = 2'h0;
        endcase
    endfunction

    // ----------------------------------------
    // Bus decode and handshake
    // ----------------------------------------
    // Word index from byte address
    assign reg_idx = avs_address_i[4:2];
    assign busy = ~phase_q[0];
    // Writes stall while an instruction runs
    assign wr_accept = avs_write_i & ~busy;
    // Reads complete after the wait counter expires, never while busy
    assign rd_accept = avs_read_i & ~busy & (rd_cnt_q == `AAR_RD_WAIT);
    assign avs_waitrequest_o = (avs_write_i & busy)
                             | (avs_read_i & ~rd_accept);
    // Writing the instruction register launches an instruction
    assign start = wr_accept & (reg_idx == `AAR_IDX_INSTR);
    assign instr_merged = be_merge({2'b00, instr_q}, avs_writedata_i[15:0],
                                   avs_byteenable_i[1:0]) & 16'h3fff;

    // Read wait counter: address, memory latch, answer
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_cnt_q <= 2'h0;
        end
        else if (!avs_read_i || busy || rd_accept)
        begin
            rd_cnt_q <= 2'h0;
        end
        else
        begin
            rd_cnt_q <= rd_cnt_q + 2'h1;
        end
    end

    // Read data register
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (avs_read_i && !busy)
        begin
            case (reg_idx)
                `AAR_IDX_INSTR: avs_readdata_o <= {18'h0_0000, instr_q};
                `AAR_IDX_ACC: avs_readdata_o <= {{(32-WIDTH){1'b0}}, acc_q};
                `AAR_IDX_STATUS: avs_readdata_o <= {27'h000_0000, illegal_q, busy,
                                                    zero_q, dcarry_q, carry_q};
                `AAR_IDX_FADDR: avs_readdata_o <= {{(32-AW){1'b0}}, faddr_q};
                `AAR_IDX_FDATA: avs_readdata_o <= {{(32-WIDTH){1'b0}}, mem_rdata};
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    // Four phases per instruction, then back to idle
    always @*
    begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE:
            begin
                if (start)
                begin
                    phase_d = PH_Q1;
                end
            end
            PH_Q1: phase_d = PH_Q2;
            PH_Q2: phase_d = PH_Q3;
            PH_Q3: phase_d = PH_Q4;
            PH_Q4: phase_d = PH_IDLE;
            default: phase_d = PH_IDLE;
        endcase
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_q <= PH_IDLE;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

    // Instruction register, loaded by the launching write
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            instr_q <= `AAR_RST_INSTR;
        end
        else if (start)
        begin
            instr_q <= instr_merged[13:0];
        end
    end

    // Q1: decode opcode, destination and file address
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            op_add_q <= 1'b0;
            op_and_q <= 1'b0;
            dest_file_q <= 1'b0;
            op_addr_q <= {AW{1'b0}};
        end
        else if (phase_q[1])
        begin
            op_add_q <= op_decode(instr_q) == 2'h1;
            op_and_q <= op_decode(instr_q) == 2'h2;
            dest_file_q <= instr_q[`AAR_DEST_BIT];
            op_addr_q <= instr_q[`AAR_ADDR_HI:`AAR_ADDR_LO];
        end
    end
    assign op_valid = op_add_q | op_and_q;

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    // Memory port: core owns it while busy, software otherwise
    assign mem_addr = busy ? op_addr_q : faddr_q;
    assign mem_we = (phase_q[4] & op_valid & dest_file_q)
                  | (wr_accept & (reg_idx == `AAR_IDX_FDATA));
    assign mem_wdata = busy ? result_q : avs_writedata_i[WIDTH-1:0];

    aar_regfile #(.WIDTH(WIDTH), .AW(AW)) u_regfile (
        .clock_i(clock_i),
        .addr_i(mem_addr),
        .wr_en_i(mem_we),
        .wr_data_i(mem_wdata),
        .rd_data_o(mem_rdata)
    );
    aar_alu #(.WIDTH(WIDTH)) u_alu (
        .acc_i(acc_q),
        .file_i(mem_rdata),
        .add_sel_i(op_add_q),
        .result_o(alu_result),
        .carry_o(alu_c),
        .digit_carry_o(alu_dcy),
        .zero_o(alu_z)
    );

    // Q3: latch result and flags while file data is valid
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            result_q <= {WIDTH{1'b0}};
            res_c_q <= 1'b0;
            res_dcy_q <= 1'b0;
            res_z_q <= 1'b0;
        end
        else if (phase_q[3])
        begin
            result_q <= alu_result;
            res_c_q <= alu_c;
            res_dcy_q <= alu_dcy;
            res_z_q <= alu_z;
        end
    end

    // Q4: accumulator destination, or software write
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_q <= `AAR_RST_ACC;
        end
        else if (phase_q[4] && op_valid && !dest_file_q)
        begin
            acc_q <= result_q;
        end
        else if (wr_accept && reg_idx == `AAR_IDX_ACC && avs_byteenable_i[0])
        begin
            acc_q <= avs_writedata_i[WIDTH-1:0];
        end
    end

    // Q4: flags by operation; AND leaves carries alone
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            carry_q <= 1'b0;
            dcarry_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else if (phase_q[4] && op_valid)
        begin
            zero_q <= res_z_q;
            if (op_add_q)
            begin
                carry_q <= res_c_q;
                dcarry_q <= res_dcy_q;
            end
        end
        else if (wr_accept && reg_idx == `AAR_IDX_STATUS && avs_byteenable_i[0])
        begin
            carry_q <= avs_writedata_i[`AAR_BIT_CARRY];
            dcarry_q <= avs_writedata_i[`AAR_BIT_DCARRY];
            zero_q <= avs_writedata_i[`AAR_BIT_ZERO];
        end
    end

    // Sticky unknown-opcode flag; set wins over a software clear
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            illegal_q <= 1'b0;
        end
        else if (phase_q[4] && !op_valid)
        begin
            illegal_q <= 1'b1;
        end
        else if (wr_accept && reg_idx == `AAR_IDX_STATUS && avs_byteenable_i[0]
                 && avs_writedata_i[`AAR_BIT_ILLEGAL])
        begin
            illegal_q <= 1'b0;
        end
    end

    // File address pointer for software access
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            faddr_q <= `AAR_RST_FADDR;
        end
        else if (wr_accept && reg_idx == `AAR_IDX_FADDR && avs_byteenable_i[0])
        begin
            faddr_q <= avs_writedata_i[AW-1:0];
        end
    end

    // ----------------------------------------
    // Observation outputs
    // ----------------------------------------
    assign acc_o = acc_q;
    assign carry_flag_o = carry_q;
    assign digit_carry_flag_o = dcarry_q;
    assign zero_flag_o = zero_q;
    assign busy_o = busy;

endmodule // aar_core

// ### aar_core_properties.sv
`timescale 1ns/10ps
`include "aar_defines.vh"
// ----------------------------------------
// Port checker for the add and AND datapath
// ----------------------------------------
module aar_core_properties #(
    parameter WIDTH = 8,
    parameter AW = 7
)
(
    input wire clock_i, // Core clock
    input wire rst_n_i, // Reset, active low
    input wire [4:0] avs_address_i, // Byte address
    input wire avs_read_i, // Read request
    input wire avs_write_i, // Write request
    input wire [31:0] avs_writedata_i, // Write data
    input wire [3:0] avs_byteenable_i, // Byte lanes
    input wire [31:0] avs_readdata_o, // Read data
    input wire avs_waitrequest_o, // Stall
    input wire [WIDTH-1:0] acc_o, // Accumulator
    input wire carry_flag_o, // Carry flag
    input wire digit_carry_flag_o, // Digit carry flag
    input wire zero_flag_o, // Zero flag
    input wire busy_o // Instruction running
);
    reg is_and_q;
    reg to_file_q;
    reg ok_q;
    wire wr_done = avs_write_i && !avs_waitrequest_o;
    wire instr_wr = wr_done && (avs_address_i[4:2] == `AAR_IDX_INSTR);
    wire legal_op = (avs_writedata_i[13:10] == 4'h1) && avs_writedata_i[8];
    // Kind and destination of the launched instruction
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            is_and_q <= 1'h0;
            to_file_q <= 1'h0;
            ok_q <= 1'h0;
        end
        else if (instr_wr)
        begin
            ok_q <= legal_op;
            is_and_q <= (avs_writedata_i[13:8] == `AAR_OPC_AND);
            to_file_q <= avs_writedata_i[`AAR_DEST_BIT];
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_launch_busy: assert property (instr_wr && legal_op
        |=> busy_o[*4] ##1 !busy_o) else $error("instruction phases not four cycles");
    chk_write_stall: assert property (busy_o && avs_write_i |-> avs_waitrequest_o)
        else $error("write accepted while busy");
    chk_idle_write: assert property (avs_write_i && !busy_o |-> !avs_waitrequest_o)
        else $error("idle write stalled");
    chk_read_wait: assert property ($rose(avs_read_i) && !busy_o |->
        avs_waitrequest_o[*2] ##1 !avs_waitrequest_o) else $error("read wait not two cycles");
    chk_and_keeps_c: assert property (busy_o && is_and_q |=>
        $stable(carry_flag_o) && $stable(digit_carry_flag_o)) else $error("AND moved carry");
    chk_file_keeps_acc: assert property (busy_o && to_file_q |=> $stable(acc_o))
        else $error("file destination changed accumulator");
    chk_acc_zero: assert property ($fell(busy_o) && ok_q && !to_file_q |->
        zero_flag_o == (acc_o == 8'h00)) else $error("zero flag disagrees with accumulator");
    chk_quiet_state: assert property (!busy_o && !wr_done |=> $stable(acc_o) &&
        $stable({carry_flag_o, digit_carry_flag_o, zero_flag_o}))
        else $error("state changed outside write phase");
endmodule // aar_core_properties

bind aar_core aar_core_properties #(.WIDTH(WIDTH), .AW(AW)) i_props (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
    .digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o), .busy_o(busy_o)
);

// ### aar_core_bench.sv
`timescale 1ns/10ps
`include "aar_defines.vh"
module aar_core_bench;
    reg clock_i = 1'h0;
    reg rst_n_i = 1'h0;
    reg [4:0] avs_address_i = 5'h00;
    reg avs_read_i = 1'h0;
    reg avs_write_i = 1'h0;
    reg [31:0] avs_writedata_i = 32'h0000_0000;
    reg [3:0] avs_byteenable_i = 4'hf;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    wire [7:0] acc_o;
    wire carry_flag_o;
    wire digit_carry_flag_o;
    wire zero_flag_o;
    wire busy_o;
    integer errors = 0;
    integer checks_done = 0;
    integer seed = 8;
    integer n;
    reg [31:0] rv;
    reg [31:0] rw;
    reg [31:0] exp_q[$];
    reg [7:0] m_acc;
    reg m_c = 1'h0;
    reg m_dcy = 1'h0;
    reg m_z = 1'h0;
    reg m_ill = 1'h0;

    aar_core #(.WIDTH(8), .AW(7)) i_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
        .digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o), .busy_o(busy_o)
    );

    // ----------------------------------------
    // Clock, compare and closing
    // ----------------------------------------
    initial
    begin
        forever #4 clock_i = ~clock_i;
    end

    task automatic check(input string what, input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic [31:0] status_word;
        status_word = {27'h0, m_ill, 1'h0, m_z, m_dcy, m_c};
    endfunction

    // ----------------------------------------
    // Bus master, request held until accepted
    // ----------------------------------------
    task automatic bus(input is_rd, input [2:0] idx, input [31:0] data);
        avs_address_i <= {idx, 2'h0};
        avs_read_i <= is_rd;
        avs_write_i <= !is_rd;
        avs_writedata_i <= data;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'h0)
            @(posedge clock_i);
    endtask

    task automatic rd(input [2:0] idx, input [31:0] exp);
        exp_q.push_back(exp);
        bus(1'h1, idx, 32'h0000_0000);
    endtask

    task automatic idle;
        avs_read_i <= 1'h0;
        avs_write_i <= 1'h0;
        @(posedge clock_i);
    endtask

    // Read results taken at the accepting edge
    always @(posedge clock_i)
    begin
        if (rst_n_i && avs_read_i && avs_waitrequest_o === 1'h0)
        begin
            if (exp_q.size() == 0)
                check("unexpected read", 32'h0000_0001, 32'h0000_0000);
            else
                check("read data", avs_readdata_o, exp_q.pop_front());
        end
    end

    // ----------------------------------------
    // One instruction against the reference
    // ----------------------------------------
    task automatic run_op(input is_add, input d, input [6:0] a, input [7:0] w,
        input [7:0] f, input [2:0] fl);
        reg [8:0] s;
        reg [4:0] h;
        reg [7:0] r;
        {m_z, m_dcy, m_c} = fl;
        m_ill = 1'h0;
        bus(1'h0, `AAR_IDX_STATUS, {27'h0, 1'h1, 1'h0, fl});
        bus(1'h0, `AAR_IDX_ACC, {24'h0, w});
        bus(1'h0, `AAR_IDX_FADDR, {25'h0, a});
        bus(1'h0, `AAR_IDX_FDATA, {24'h0, f});
        s = w + f;
        h = w[3:0] + f[3:0];
        r = is_add ? s[7:0] : (w & f);
        if (is_add)
        begin
            m_c = s[8];
            m_dcy = h[4];
        end
        m_z = (r == 8'h00);
        m_acc = d ? w : r;
        bus(1'h0, `AAR_IDX_INSTR, {18'h0, is_add ? 6'h07 : 6'h05, d, a});
        avs_write_i <= 1'h0;
        @(posedge clock_i);
        check("busy port", {31'h0, busy_o}, 32'h0000_0001);
        rd(`AAR_IDX_ACC, {24'h0, m_acc});
        rd(`AAR_IDX_FDATA, {24'h0, d ? r : f});
        rd(`AAR_IDX_STATUS, status_word());
        idle;
        check("acc port", {24'h0, acc_o}, {24'h0, m_acc});
        check("flag ports", {29'h0, carry_flag_o, digit_carry_flag_o, zero_flag_o},
            {29'h0, m_c, m_dcy, m_z});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'h1;
        @(posedge clock_i);
        run_op(1'h1, 1'h0, 7'h05, 8'h0f, 8'h01, 3'h0);
        run_op(1'h1, 1'h1, 7'h7f, 8'hff, 8'h01, 3'h0);
        run_op(1'h0, 1'h0, 7'h00, 8'hf0, 8'h0f, 3'h3);
        run_op(1'h0, 1'h1, 7'h40, 8'hff, 8'hff, 3'h7);
        $display("directed operations done");
        for (n = 0; n < 40; n = n + 1)
        begin
            rv = $random(seed);
            rw = $random(seed);
            run_op(rv[0], rv[1], rv[8:2], rv[16:9], rw[7:0], rw[10:8]);
        end
        $display("random operations done");
        bus(1'h0, `AAR_IDX_INSTR, {18'h0, 6'h3f, 8'h00});
        bus(1'h0, `AAR_IDX_FADDR, 32'h0000_0011);
        m_ill = 1'h1;
        rd(`AAR_IDX_STATUS, status_word());
        rd(`AAR_IDX_ACC, {24'h0, m_acc});
        rd(`AAR_IDX_INSTR, {18'h0, 6'h3f, 8'h00});
        rd(`AAR_IDX_FADDR, 32'h0000_0011);
        avs_byteenable_i <= 4'he;
        bus(1'h0, `AAR_IDX_ACC, 32'h0000_00a5);
        avs_byteenable_i <= 4'hf;
        rd(`AAR_IDX_ACC, {24'h0, m_acc});
        bus(1'h0, `AAR_IDX_STATUS, {27'h0, 1'h1, 1'h0, m_z, m_dcy, m_c});
        m_ill = 1'h0;
        rd(`AAR_IDX_STATUS, status_word());
        bus(1'h0, 3'h7, rv);
        rd(3'h7, 32'h0000_0000);
        rd(3'h5, 32'h0000_0000);
        idle;
        $display("register map tests done");
        repeat (4) @(posedge clock_i);
        check("pending reads", exp_q.size(), 32'h0000_0000);
        finish_test;
    end

    // Cut a hang short
    initial
    begin
        #200_000;
        errors = errors + 1;
        finish_test;
    end
endmodule // aar_core_bench
